//--- hdl/cvpc_top.sv
// Purpose: converter pin control, calibration and output demux
// Assumes: pins and sample clock are asynchronous to pclk
// Notes: sample clock edges are found by oversampling on pclk
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "cvpc_regs.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// - calibration starts 640 cycles after qualified request rise
// - request high at power-up skips power-on calibration
// - delay select chooses short or long power-on delay
// - full power-down at power-up halts the delay counter
// - extended control always uses the short delay
// - edge select high: data change on rising clock edge
// - swing select picks strong or low power drive
// - dual edge: I input feeds both converters on opposite edges
// - floating shared pin selects short delay, and dual edge in plain control
// - powered down channel outputs float; receiver flushes pipeline
// - full power-down stops all; Q power-down stops Q only
// - full power-down waits for running calibration to finish
// - calibration request ignored while powered down
// - odd and even conversions go to separate buses
// - double data rate: word per clock edge, clock at 1/4
// - codes are offset binary, passed through unchanged
// - calibration_running high for whole calibration
// - output data clock frozen during calibration
module cvpc_top import cvpc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_clk,
	input wire logic cal_request,
	input wire logic calibration_delay_select,
	input wire logic power_down_all,
	input wire logic power_down_second_channel,
	input wire logic output_edge_select,
	input wire logic output_swing_select,
	input wire logic des_pin_float,
	input wire logic [7:0] conv_i_data,
	input wire logic [7:0] conv_q_data,
	output logic calibration_running,
	output logic output_data_clock,
	output logic [7:0] out_i_odd,
	output logic [7:0] out_i_even,
	output logic [7:0] out_q_odd,
	output logic [7:0] out_q_even,
	output logic out_i_oe,
	output logic out_q_oe,
	output logic drive_strong,
	output logic des_active,
	output logic auto_phase_ctrl
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers

logic [23:0] pin_raw;
logic [23:0] s1_r;
logic [23:0] s2_r;
logic sclk_d_r;

assign pin_raw = {conv_q_data, conv_i_data, sample_clk, cal_request,
	calibration_delay_select, power_down_all,
	power_down_second_channel, output_edge_select,
	output_swing_select, des_pin_float};

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		s1_r <= 24'h000000;
		s2_r <= 24'h000000;
		sclk_d_r <= 1'b0;
	end else begin
		s1_r <= pin_raw;
		s2_r <= s1_r;
		sclk_d_r <= s2_r[7];
	end
end

logic sclk_s, cal_s, dly_s, pd_s, pdq_s, oes_s, ovs_s, flt_s;
logic [7:0] di_s;
logic [7:0] dq_s;
logic rise, fall;
assign {dq_s, di_s, sclk_s, cal_s, dly_s, pd_s} = s2_r[23:4];
assign {pdq_s, oes_s, ovs_s, flt_s} = s2_r[3:0];
assign rise = sclk_s && !sclk_d_r;
assign fall = !sclk_s && sclk_d_r;

////////////////////////////////////////////////////////////////////////
// apb registers

logic [1:0] ctrl_r, ctrl_nxt;
logic [15:0] des_r, des_nxt;
logic [31:0] stat;
logic hit_ctrl, hit_stat, hit_des, wr;

assign hit_ctrl = paddr[11:2] == `CVPC_CTRL_IDX;
assign hit_stat = paddr[11:2] == `CVPC_STAT_IDX;
assign hit_des = paddr[11:2] == `CVPC_DES_IDX;
assign wr = psel && penable && pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && !(hit_ctrl || hit_stat || hit_des);

always_comb begin
	ctrl_nxt = ctrl_r;
	des_nxt = des_r;
	if (wr && hit_ctrl) begin
		ctrl_nxt = pwdata[1:0];
	end
	if (wr && hit_des) begin
		des_nxt = pwdata[15:0];
	end
	prdata = 32'h00000000;
	if (hit_ctrl) begin
		prdata = {30'h00000000, ctrl_r};
	end else if (hit_stat) begin
		prdata = stat;
	end else if (hit_des) begin
		prdata = {16'h0000, des_r};
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_r <= `CVPC_CTRL_RST;
		des_r <= `CVPC_DES_RST;
	end else begin
		ctrl_r <= ctrl_nxt;
		des_r <= des_nxt;
	end
end

logic ext, ddr;
assign ext = ctrl_r[`CVPC_CTRL_EXT];
assign ddr = ctrl_r[`CVPC_CTRL_DDR];
// shared pin floating selects dual edge without extended control
assign des_active = ext ? des_r[`CVPC_DES_ON] : flt_s;
assign auto_phase_ctrl = ext && des_r[`CVPC_DES_APC];

////////////////////////////////////////////////////////////////////////
// calibration sequencer and output path

cvpc_cal_e st_r, st_nxt;
logic [9:0] lo_r, lo_nxt, hi_r, hi_nxt;
logic [12:0] dly_r, dly_nxt, dly_lim;
logic [10:0] run_r, run_nxt;
logic par_r, par_nxt, output_data_clock_r, output_data_clock_nxt, sw_r, sw_nxt;
logic [7:0] ia_r, ia_nxt, qa_r, qa_nxt, qb_r, qb_nxt;
logic [7:0] oio_r, oio_nxt, oie_r, oie_nxt;
logic [7:0] oqo_r, oqo_nxt, oqe_r, oqe_nxt;
logic pd_state, go, launch;

// delay select honoured only in plain control with the pin driven
assign dly_lim = (dly_s && !ext && !flt_s) ? `CVPC_DLY_LONG :
	`CVPC_DLY_SHORT;
// full power-down held off while calibrating
assign pd_state = pd_s && st_r != CAL_RUN;
assign calibration_running = st_r == CAL_RUN;
assign launch = fall && par_r && st_r != CAL_RUN;

always_comb begin
	st_nxt = st_r;
	lo_nxt = lo_r;
	hi_nxt = hi_r;
	dly_nxt = dly_r;
	run_nxt = run_r;
	go = 1'b0;
	if (rise) begin
		if (pd_state) begin
			lo_nxt = 10'h000;
			hi_nxt = 10'h000;
		end else if (!cal_s) begin
			hi_nxt = 10'h000;
			if (lo_r != `CVPC_QUAL_CYC) begin
				lo_nxt = lo_r + 10'h001;
			end
		end else if (lo_r == `CVPC_QUAL_CYC) begin
			if (hi_r == `CVPC_QUAL_CYC - 10'h001) begin
				go = 1'b1;
				lo_nxt = 10'h000;
				hi_nxt = 10'h000;
			end else begin
				hi_nxt = hi_r + 10'h001;
			end
		end else begin
			lo_nxt = 10'h000;
		end
		unique case (st_r)
			CAL_BOOT: begin
				// request high at power-up: wait for a command
				st_nxt = cal_s ? CAL_IDLE : CAL_DELAY;
			end
			CAL_DELAY: begin
				if (go) begin
					st_nxt = CAL_RUN;
				end else if (!pd_s) begin
					if (dly_r == dly_lim - 13'h0001) begin
						st_nxt = CAL_RUN;
					end else begin
						dly_nxt = dly_r + 13'h0001;
					end
				end
			end
			CAL_IDLE: begin
				if (go) begin
					st_nxt = CAL_RUN;
				end
			end
			CAL_RUN: begin
				if (run_r == `CVPC_RUN_CYC - 11'h001) begin
					st_nxt = CAL_IDLE;
					run_nxt = 11'h000;
				end else begin
					run_nxt = run_r + 11'h001;
				end
			end
		endcase
	end
end

always_comb begin
	par_nxt = par_r;
	output_data_clock_nxt = output_data_clock_r;
	ia_nxt = ia_r;
	qa_nxt = qa_r;
	qb_nxt = qb_r;
	oio_nxt = oio_r;
	oie_nxt = oie_r;
	oqo_nxt = oqo_r;
	oqe_nxt = oqe_r;
	sw_nxt = ovs_s;
	// dual edge: Q converter takes I input on the other edge
	if (rise && des_active) begin
		if (par_r) begin
			qb_nxt = di_s;
		end else begin
			qa_nxt = di_s;
		end
	end
	if (fall) begin
		par_nxt = !par_r;
		if (!par_r) begin
			ia_nxt = di_s;
			if (!des_active) begin
				qa_nxt = dq_s;
			end
		end
	end
	if (fall && st_r != CAL_RUN) begin
		if (!ddr) begin
			// launch edge direction follows edge select
			output_data_clock_nxt = par_r ? oes_s : !oes_s;
		end else if (par_r) begin
			output_data_clock_nxt = !output_data_clock_r;
		end
	end
	if (launch) begin
		// codes leave unchanged as offset binary
		oio_nxt = ia_r;
		oie_nxt = di_s;
		oqo_nxt = qa_r;
		oqe_nxt = des_active ? qb_r : dq_s;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		st_r <= CAL_BOOT;
		lo_r <= 10'h000;
		hi_r <= 10'h000;
		dly_r <= 13'h0000;
		run_r <= 11'h000;
		par_r <= 1'b0;
		output_data_clock_r <= 1'b0;
		sw_r <= 1'b0;
		ia_r <= 8'h00;
		qa_r <= 8'h00;
		qb_r <= 8'h00;
		oio_r <= 8'h00;
		oie_r <= 8'h00;
		oqo_r <= 8'h00;
		oqe_r <= 8'h00;
	end else begin
		st_r <= st_nxt;
		lo_r <= lo_nxt;
		hi_r <= hi_nxt;
		dly_r <= dly_nxt;
		run_r <= run_nxt;
		par_r <= par_nxt;
		output_data_clock_r <= output_data_clock_nxt;
		sw_r <= sw_nxt;
		ia_r <= ia_nxt;
		qa_r <= qa_nxt;
		qb_r <= qb_nxt;
		oio_r <= oio_nxt;
		oie_r <= oie_nxt;
		oqo_r <= oqo_nxt;
		oqe_r <= oqe_nxt;
	end
end

assign output_data_clock = output_data_clock_r;
assign drive_strong = sw_r;
assign out_i_odd = oio_r;
assign out_i_even = oie_r;
assign out_q_odd = oqo_r;
assign out_q_even = oqe_r;
// powered down channels release their data lines
assign out_i_oe = !pd_state;
assign out_q_oe = !pd_state && !pdq_s;
assign stat = {27'h0000000, lo_r == `CVPC_QUAL_CYC, des_active,
	!out_q_oe, pd_state, calibration_running};

////////////////////////////////////////////////////////////////////////
// assertions

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

a_cal_start_qual: assert property (
	$rose(calibration_running) && $past(st_r) == CAL_IDLE |->
	$past(cal_s) && $past(hi_r) == `CVPC_QUAL_CYC - 10'h001)
	else $error("calibration started without qualified request");
a_cal_run_len: assert property (
	$rose(calibration_running) |-> run_r == 11'h000)
	else $error("calibration counter not cleared at start");
a_pd_ignore: assert property (
	pd_state |=> !$rose(calibration_running))
	else $error("calibration began while powered down");
a_pd_after_cal: assert property (
	calibration_running && pd_s ##1 !calibration_running |->
	out_i_oe == 1'b0)
	else $error("power down not entered after calibration");
a_output_data_clock_frozen: assert property (
	calibration_running && $past(calibration_running) |->
	$stable(output_data_clock))
	else $error("data clock toggled during calibration");
a_hiz_pd: assert property (
	pd_s && !calibration_running |-> !out_i_oe && !out_q_oe)
	else $error("outputs driven while powered down");
a_q_only_pd: assert property (
	pdq_s && !pd_s |-> out_i_oe && !out_q_oe)
	else $error("Q power down affected I channel");
a_swing_follow: assert property (
	$changed(ovs_s) |=> drive_strong == $past(ovs_s))
	else $error("drive level did not follow swing select");
a_delay_hold: assert property (
	st_r == CAL_DELAY && pd_s |=> $stable(dly_r))
	else $error("delay counter ran during power down");
a_short_ext: assert property (
	ext |-> dly_lim == `CVPC_DLY_SHORT)
	else $error("long delay in extended control");
a_sdr_edge: assert property (
	launch && !ddr |=> output_data_clock == $past(oes_s))
	else $error("data launched on wrong clock edge");

c_cal_run: cover property ($rose(calibration_running));
c_pd_during_cal: cover property (calibration_running && pd_s);
c_ddr_launch: cover property (launch && ddr);
c_des_launch: cover property (launch && des_active);

endmodule

//--- hdl/cvpc_regs.svh
// Purpose: constants of the converter pin control block
// Assumes: counts are in sample clock cycles
// Notes: register byte address is four times its index
`ifndef CVPC_REGS_SVH
`define CVPC_REGS_SVH
`define CVPC_QUAL_CYC 10'h280
`define CVPC_DLY_SHORT 13'h0400
`define CVPC_DLY_LONG 13'h1000
`define CVPC_RUN_CYC 11'h578
`define CVPC_CTRL_IDX 10'h000
`define CVPC_STAT_IDX 10'h001
`define CVPC_DES_IDX 10'h00D
`define CVPC_CTRL_DDR 0
`define CVPC_CTRL_EXT 1
`define CVPC_DES_APC 14
`define CVPC_DES_ON 15
`define CVPC_CTRL_RST 2'h0
`define CVPC_DES_RST 16'h4000
`endif

//--- hdl/cvpc_pkg.sv
// Purpose: types of the converter pin control block
// Assumes: nothing
// Notes: calibration sequencer states
package cvpc_pkg;
	typedef enum logic [1:0] {
		CAL_BOOT,
		CAL_DELAY,
		CAL_IDLE,
		CAL_RUN
	} cvpc_cal_e;
endpackage

//--- verif/cvpc_far_end.sv
// Purpose: far side model, sample clock, converter words, capture
// Assumes: sample clock of 64 ns runs free, unrelated to pclk
// it never stops or jumps, so auto phase stays legal
// Notes: I word steps by one each rise; Q word is its inverse
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module cvpc_far_end (
	input wire logic [7:0] base,
	input wire logic output_data_clock,
	output logic sample_clk,
	output logic [7:0] conv_i_data,
	output logic [7:0] conv_q_data,
	output int rises,
	output int toggles
);
	int rise_cnt = 0;
	int tog_cnt = 0;
	initial begin
		sample_clk = 1'b0;
		#3;
		forever #32 sample_clk = ~sample_clk;
	end
	// new word at each rise, stable over the falling edge
	always @(posedge sample_clk) begin
		rise_cnt <= rise_cnt + 1;
	end
	assign rises = rise_cnt;
	assign conv_i_data = base + rise_cnt[7:0];
	assign conv_q_data = ~conv_i_data;
	// capture side counts data clock edges
	always @(output_data_clock) begin
		tog_cnt = tog_cnt + 1;
	end
	assign toggles = tog_cnt;
endmodule

//--- verif/cvpc_top_tb_top.sv
// Purpose: self-checking bench of the converter pin control block
// Assumes: design answers apb at once; sample clock from far end model
// Notes: calibration request driven between sample clock rises
`timescale 1ns/1ps
`include "cvpc_regs.svh"
////////////////////////////////////////////////////////////////////////
module cvpc_top_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sample_clk, cal_request, power_down_all, er, mon_on, ddr;
	logic power_down_second_channel, output_edge_select;
	logic output_swing_select, calibration_running, output_data_clock;
	logic [7:0] conv_i_data, conv_q_data, base, prev_odd;
	logic [7:0] out_i_odd, out_i_even, out_q_odd, out_q_even;
	logic out_i_oe, out_q_oe, drive_strong, prev_clk, prev_run;
	logic calibration_delay_select, des_pin_float, des_active;
	logic auto_phase_ctrl;
	int mismatches, compares, seed, rises, toggles, t, i;
	cvpc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sample_clk, .cal_request,
		.calibration_delay_select, .power_down_all,
		.power_down_second_channel, .output_edge_select,
		.output_swing_select, .des_pin_float, .conv_i_data,
		.conv_q_data, .calibration_running, .output_data_clock,
		.out_i_odd, .out_i_even, .out_q_odd, .out_q_even, .out_i_oe,
		.out_q_oe, .drive_strong, .des_active, .auto_phase_ctrl);
	cvpc_far_end far_u (.base, .output_data_clock, .sample_clk,
		.conv_i_data, .conv_q_data, .rises, .toggles);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			end_of_test;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rises_wait(input int n);
		int e, k;
		e = rises + n;
		k = 0;
		while (rises < e) begin
			@(posedge pclk);
			k++;
			if (k > n * 16 + 16) begin
				mismatches++;
				end_of_test;
			end
		end
	endtask
	// low for lo rises, then high; hi rises waited after the rise
	task req_seq(input int lo, input int hi);
		rises_wait(1);
		repeat (6) @(posedge pclk);
		cal_request <= 1'b0;
		rises_wait(lo);
		repeat (6) @(posedge pclk);
		cal_request <= 1'b1;
		rises_wait(hi);
	endtask
	////////////////////////////////////////////////////////////////////
	// model: odd word earlier, even word next, q word the inverse
	always @(posedge pclk) begin
		if (mon_on && out_i_oe === 1'b1 && out_i_odd !== prev_odd) begin
			chk("even word", 32'(8'(out_i_odd + 8'h01)),
				32'(out_i_even));
			chk("q word", 32'(8'(~out_i_odd)), 32'(out_q_odd));
			chk("q even", 32'(8'(~out_i_even)), 32'(out_q_even));
			if (!ddr) chk("clk at launch", 32'(output_edge_select),
				32'(output_data_clock));
		end
		if (prev_run === 1'b1 && calibration_running === 1'b1 &&
			output_data_clock !== prev_clk)
			chk("clk frozen", 32'(prev_clk),
				32'(output_data_clock));
		prev_odd <= out_i_odd;
		prev_clk <= output_data_clock;
		prev_run <= calibration_running;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h473b0a98;
		base = 8'($random(seed));
		calibration_delay_select = 1'b0;
		des_pin_float = 1'b0; // shared pin pulled low first
		{psel, penable, pwrite, mon_on, ddr} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		presetn = 1'b0;
		cal_request = 1'b1;
		{power_down_all, power_down_second_channel} = 2'h0;
		{output_edge_select, output_swing_select} = 2'h0;
		mismatches = 0;
		compares = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, 12'h034, 32'h0);
		chk("des reset", 32'(`CVPC_DES_RST), rd);
		apb(1'b1, 12'h008, 32'hFFFFFFFF);
		chk("unmapped err", 32'h1, 32'(er));
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 12'h000, 32'h2);
		chk("apc on", 32'h1, 32'(auto_phase_ctrl));
		apb(1'b1, 12'h034, 32'h0);
		chk("apc off", 32'h0, 32'(auto_phase_ctrl));
		apb(1'b1, 12'h000, 32'h0);
		$display("test registers done");
		rises_wait(20);
		mon_on <= 1'b1;
		rises_wait(380);
		req_seq(645, 0); // normal mode only
		chk("no power-on cal", 32'h0,
			32'(calibration_running));
		rises_wait(639);
		chk("cal early", 32'h0, 32'(calibration_running));
		rises_wait(1);
		repeat (8) @(posedge pclk);
		chk("cal start", 32'h1,
			32'(calibration_running));
		rises_wait(60);
		mon_on <= 1'b0;
		power_down_all <= 1'b1;
		rises_wait(1338);
		chk("cal held", 32'h1, 32'(calibration_running));
		chk("pd deferred", 32'h1, 32'(out_i_oe));
		rises_wait(3); // end read from calibration_running
		repeat (8) @(posedge pclk);
		chk("cal end", 32'h0, 32'(calibration_running));
		chk("i float", 32'h0, 32'(out_i_oe));
		chk("q float", 32'h0, 32'(out_q_oe));
		$display("test calibration done");
		req_seq(645, 645);
		chk("pd ignores req", 32'h0,
			32'(calibration_running));
		power_down_all <= 1'b0;
		power_down_second_channel <= 1'b1;
		rises_wait(4);
		chk("i on", 32'h1, 32'(out_i_oe));
		chk("q off", 32'h0, 32'(out_q_oe));
		power_down_second_channel <= 1'b0;
		rises_wait(6);
		mon_on <= 1'b1; // stale words flushed first
		$display("test power down done");
		for (i = 0; i < 4; i++) begin
			output_edge_select <= 1'($random(seed));
			output_swing_select <= 1'($random(seed));
			rises_wait(8);
			chk("drive", 32'(output_swing_select),
				32'(drive_strong));
		end
		t = toggles;
		rises_wait(16);
		chk("sdr edges", 32'd16, 32'(toggles - t));
		apb(1'b1, 12'h000, 32'h1);
		ddr <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl rw", 32'h1, rd);
		rises_wait(8);
		t = toggles;
		rises_wait(16);
		chk("ddr edges", 32'd8, 32'(toggles - t));
		mon_on <= 1'b0;
		des_pin_float <= 1'b1;
		rises_wait(2);
		chk("des on", 32'h1, 32'(des_active));
		des_pin_float <= 1'b0;
		rises_wait(2);
		chk("des off", 32'h0, 32'(des_active));
		$display("test output clocking done");
		end_of_test;
	end
endmodule
